//--- rtl/equalizer_fir_bank.sv
// channel a equalizer fir: low tap coefficient bank, config, apb slave, datapath
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
module equalizer_fir_bank
   import equalizer_fir_pkg::*;
(
   input  wire logic                                   clk_sys_i,
   input  wire logic                                   rst_n_i,
   input  wire equalizer_fir_pkg::apb_req_s            apb_i,
   output logic [equalizer_fir_pkg::DATA_W-1:0]        prdata_o,
   output logic                                        pready_o,
   output logic                                        pslverr_o,
   input  wire logic                                   serial_link_output_enable_i,
   input  wire equalizer_fir_pkg::sample_s             sample_i,
   output equalizer_fir_pkg::sample_s                  sample_o,
   output logic                                        fir_active_o
);
   import equalizer_fir_pkg::*;

   // side taps must fit their registers; one centre tap follows the side taps
   generate
      if (SIDE_W > SIDE_REG_W || CENTRE_W > CENTRE_REG_W || NUM_SIDE + 1 != NUM_TAPS)
      begin : g_chk
         $error("equalizer_fir_bank: register map does not fit the taps");
      end
   endgenerate

   // register storage
   logic [SIDE_REG_W-1:0]   side_coef_reg [NUM_SIDE];
   logic [CENTRE_REG_W-1:0] centre_tap_coefficient_reg;
   logic [CFG_REG_W-1:0]    cfg_reg;
   logic                    link_write_reg;
   logic                    fir_active_reg;

   // bus slave state
   logic                    pready_reg;
   logic                    pslverr_reg;
   logic [DATA_W-1:0]       prdata_reg;

   // decoded configuration
   filter_mode_e            filter_mode_select;
   logic [CFG_SCW_W-1:0]    side_coef_weight_raw;
   logic [CFG_SCW_W-1:0]    side_coef_weight;
   logic                    filter_merge;
   logic                    filter_enable;

   // bus decode
   logic                    access;
   logic                    first_access;
   logic                    do_write;
   logic                    addr_hit;
   logic [DATA_W-1:0]       read_data;
   logic                    filter_reg_write;
   logic                    link_write_set;
   logic                    link_write_clear;

   // per register decode
   logic [NUM_SIDE-1:0]     side_hit;
   logic                    centre_hit;
   logic                    cfg_hit;
   logic                    status_hit;
   logic [NUM_SIDE-1:0]     side_write;
   logic                    centre_write;
   logic                    cfg_write;
   logic                    status_write;

   // coefficient bus to the datapath
   logic [NUM_TAPS-1:0][COEF_W-1:0] coef_bus;
   logic                    mac_valid;
   logic [SAMPLE_W-1:0]     mac_data;

   // side register slot for an address, or NUM_SIDE when none
   function automatic int side_slot(input logic [ADDR_W-1:0] addr);
      if (addr == byte_addr(IDX_TAP0))
         side_slot = 0;
      else if (addr == byte_addr(IDX_TAP1))
         side_slot = 1;
      else if (addr == byte_addr(IDX_TAP2))
         side_slot = 2;
      else if (addr == byte_addr(IDX_TAP3))
         side_slot = 3;
      else
         side_slot = NUM_SIDE;
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      is_mapped = (side_slot(addr) < NUM_SIDE)
               || (addr == byte_addr(IDX_CENTRE))
               || (addr == byte_addr(IDX_CFG))
               || (addr == byte_addr(IDX_STATUS));
   endfunction

   // configuration field decode
   always_comb
   begin
      filter_mode_select   = filter_mode_e'(cfg_reg[CFG_MODE_LSB +: CFG_MODE_W]);
      side_coef_weight_raw = cfg_reg[CFG_SCW_LSB +: CFG_SCW_W];
      filter_merge         = cfg_reg[CFG_MERGE_BIT];
      // weights above the documented range are held at the top value
      side_coef_weight     = (side_coef_weight_raw > SCW_MAX) ? SCW_MAX : side_coef_weight_raw;
   end

   // only the enable code runs the filter; reserved codes stay in bypass
   always_comb
   begin
      unique case (filter_mode_select)
         FM_ENABLE : filter_enable = 1'b1;
         FM_BYPASS : filter_enable = 1'b0;
         FM_RSVD1  : filter_enable = 1'b0;
         FM_RSVD3  : filter_enable = 1'b0;
      endcase
   end

   // apb handshake: one wait state, write and read data at pready edge
   always_comb
   begin
      access       = apb_i.psel & apb_i.penable;
      first_access = access & ~pready_reg;
      addr_hit     = is_mapped(apb_i.paddr);
      do_write     = access & pready_reg & apb_i.pwrite & addr_hit;
   end

   // one hit line per register for the write enables; the read mux shares only the centre, cfg and status hits
   always_comb
   begin
      for (int i = 0; i < NUM_SIDE; i++)
      begin
         side_hit[i]   = (side_slot(apb_i.paddr) == i);
         side_write[i] = do_write && side_hit[i];
      end
      centre_hit   = (apb_i.paddr == byte_addr(IDX_CENTRE));
      cfg_hit      = (apb_i.paddr == byte_addr(IDX_CFG));
      status_hit   = (apb_i.paddr == byte_addr(IDX_STATUS));
      centre_write = do_write && centre_hit;
      cfg_write    = do_write && cfg_hit;
      status_write = do_write && status_hit;
   end

   always_comb
   begin
      read_data = '0;
      if (side_slot(apb_i.paddr) < NUM_SIDE)
      begin
         read_data[SIDE_REG_W-1:0] = side_coef_reg[side_slot(apb_i.paddr)];
      end
      else if (centre_hit)
      begin
         read_data[CENTRE_REG_W-1:0] = centre_tap_coefficient_reg;
      end
      else if (cfg_hit)
      begin
         read_data[CFG_REG_W-1:0] = cfg_reg;
      end
      else if (status_hit)
      begin
         read_data[ST_ACTIVE_BIT]   = fir_active_reg;
         read_data[ST_MERGE_BIT]    = filter_merge;
         read_data[ST_MODE_RSV_BIT] = filter_mode_select[0];
         read_data[ST_SCW_CLIP_BIT] = (side_coef_weight_raw > SCW_MAX);
         read_data[ST_LINK_WR_BIT]  = link_write_reg;
         read_data[ST_LINK_EN_BIT]  = serial_link_output_enable_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pready_reg <= 1'b0;
      end
      else
      begin
         pready_reg <= first_access;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end
      else if (first_access)
      begin
         prdata_reg  <= apb_i.pwrite ? '0 : read_data;
         pslverr_reg <= ~addr_hit;
      end
      else
      begin
         prdata_reg  <= '0;
         pslverr_reg <= 1'b0;
      end
   end

   // side coefficient registers, full 16 bits stored
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < NUM_SIDE; i++)
         begin
            side_coef_reg[i] <= SIDE_RESET;
         end
      end
      else
      begin
         for (int i = 0; i < NUM_SIDE; i++)
         begin
            if (side_write[i])
            begin
               side_coef_reg[i] <= apb_i.pwdata[SIDE_REG_W-1:0];
            end
         end
      end
   end

   // centre tap register, full 24 bits stored
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         centre_tap_coefficient_reg <= CENTRE_RESET;
      end
      else if (centre_write)
      begin
         centre_tap_coefficient_reg <= apb_i.pwdata[CENTRE_REG_W-1:0];
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cfg_reg <= CFG_RESET;
      end
      else if (cfg_write)
      begin
         cfg_reg <= apb_i.pwdata[CFG_REG_W-1:0];
      end
   end

   // sticky flag: filter register written while the serial link runs
   always_comb
   begin
      filter_reg_write = do_write && !status_hit;
      link_write_set   = filter_reg_write & serial_link_output_enable_i;
      link_write_clear = status_write && apb_i.pwdata[ST_LINK_WR_BIT];
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         link_write_reg <= 1'b0;
      end
      else if (link_write_set)
      begin
         link_write_reg <= 1'b1;
      end
      else if (link_write_clear)
      begin
         link_write_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         fir_active_reg <= 1'b0;
      end
      else
      begin
         fir_active_reg <= filter_enable;
      end
   end

   // coefficient alignment; same taps serve dual and merged operation
   generate
      for (genvar g = 0; g < NUM_SIDE; g++)
      begin : g_side
         coef_align #(
            .IN_W  (SIDE_W),
            .OUT_W (COEF_W),
            .SIDE  (1'b1)
         ) u_side (
            .raw_i    (side_coef_reg[g][SIDE_W-1:0]),
            .weight_i (side_coef_weight),
            .coef_o   (coef_bus[g])
         );
      end
   endgenerate

   coef_align #(
      .IN_W  (CENTRE_W),
      .OUT_W (COEF_W),
      .SIDE  (1'b0)
   ) u_centre (
      .raw_i    (centre_tap_coefficient_reg[CENTRE_W-1:0]),
      .weight_i (side_coef_weight),
      .coef_o   (coef_bus[CENTRE_IDX])
   );

   fir_mac #(
      .SAMPLE_W (SAMPLE_W),
      .COEF_W   (COEF_W),
      .NUM_TAPS (NUM_TAPS),
      .ACC_W    (ACC_W),
      .FRAC     (FRAC_BITS)
   ) u_mac (
      .clk_sys_i   (clk_sys_i),
      .rst_n_i     (rst_n_i),
      .enable_i    (filter_enable),
      .in_valid_i  (sample_i.valid),
      .in_data_i   (sample_i.data),
      .coef_i      (coef_bus),
      .out_valid_o (mac_valid),
      .out_data_o  (mac_data)
   );

   always_comb
   begin
      sample_o.valid = mac_valid;
      sample_o.data  = mac_data;
      prdata_o       = prdata_reg;
      pready_o       = pready_reg;
      pslverr_o      = pslverr_reg;
      fir_active_o   = fir_active_reg;
   end
endmodule

//--- rtl/equalizer_fir_pkg.sv
// constants, types and register map of the equalizer fir coefficient bank
package equalizer_fir_pkg;

   localparam int ADDR_W     = 16;
   localparam int DATA_W     = 32;
   localparam int SAMPLE_W   = 12;
   localparam int SIDE_W     = 12;
   localparam int CENTRE_W   = 18;
   localparam int COEF_W     = 20;
   localparam int NUM_TAPS   = 5;
   localparam int NUM_SIDE   = 4;
   localparam int CENTRE_IDX = 4;
   localparam int FRAC_BITS  = 16;
   localparam int ACC_W      = 36;

   // register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_CFG    = 16'h0400;
   localparam logic [ADDR_W-1:0] IDX_STATUS = 16'h0402;
   localparam logic [ADDR_W-1:0] IDX_TAP0   = 16'h0418;
   localparam logic [ADDR_W-1:0] IDX_TAP1   = 16'h041A;
   localparam logic [ADDR_W-1:0] IDX_TAP2   = 16'h041C;
   localparam logic [ADDR_W-1:0] IDX_TAP3   = 16'h041E;
   localparam logic [ADDR_W-1:0] IDX_CENTRE = 16'h0420;

   localparam int SIDE_REG_W   = 16;
   localparam int CENTRE_REG_W = 24;
   localparam int CFG_REG_W    = 8;

   localparam logic [SIDE_REG_W-1:0]   SIDE_RESET   = 16'h0000;
   localparam logic [CENTRE_REG_W-1:0] CENTRE_RESET = 24'h00_0000;
   localparam logic [CFG_REG_W-1:0]    CFG_RESET    = 8'h00;

   // configuration field positions
   localparam int CFG_MODE_LSB  = 0;
   localparam int CFG_MODE_W    = 2;
   localparam int CFG_SCW_LSB   = 2;
   localparam int CFG_SCW_W     = 3;
   localparam int CFG_MERGE_BIT = 5;
   localparam int CFG_SHARE_BIT = 6;
   localparam logic [CFG_SCW_W-1:0] SCW_MAX = 3'h6;

   // status field positions
   localparam int ST_ACTIVE_BIT   = 0;
   localparam int ST_MERGE_BIT    = 1;
   localparam int ST_MODE_RSV_BIT = 2;
   localparam int ST_SCW_CLIP_BIT = 3;
   localparam int ST_LINK_WR_BIT  = 4;
   localparam int ST_LINK_EN_BIT  = 5;

   typedef enum logic [1:0] {
      FM_BYPASS = 2'b00,
      FM_RSVD1  = 2'b01,
      FM_ENABLE = 2'b10,
      FM_RSVD3  = 2'b11
   } filter_mode_e;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic                valid;
      logic [SAMPLE_W-1:0] data;
   } sample_s;

   function automatic logic [ADDR_W-1:0] byte_addr(input logic [ADDR_W-1:0] idx);
      byte_addr = {idx[ADDR_W-3:0], 2'b00};
   endfunction

endpackage

//--- rtl/coef_align.sv
// sign extension and side weight alignment of one coefficient
`timescale 1ns/100ps
module coef_align #(
   parameter int IN_W  = 12,
   parameter int OUT_W = 20,
   parameter bit SIDE  = 1'b1
) (
   input  wire logic [IN_W-1:0]         raw_i,
   input  wire logic [2:0]              weight_i,
   output logic signed [OUT_W-1:0]      coef_o
);
   logic signed [OUT_W-1:0] ext;

   generate
      if (OUT_W < IN_W + (SIDE ? 6 : 0))
      begin : g_chk
         $error("coef_align: OUT_W too narrow for shift");
      end
   endgenerate

   always_comb
   begin
      ext = signed'({{(OUT_W-IN_W){raw_i[IN_W-1]}}, raw_i});
      coef_o = SIDE ? (ext <<< weight_i) : ext;
   end
endmodule

//--- rtl/fir_mac.sv
// tapped delay line with multiply accumulate and saturation
`timescale 1ns/100ps
module fir_mac #(
   parameter int SAMPLE_W = 12,
   parameter int COEF_W   = 20,
   parameter int NUM_TAPS = 5,
   parameter int ACC_W    = 36,
   parameter int FRAC     = 16
) (
   input  wire logic                                clk_sys_i,
   input  wire logic                                rst_n_i,
   input  wire logic                                enable_i,
   input  wire logic                                in_valid_i,
   input  wire logic [SAMPLE_W-1:0]                 in_data_i,
   input  wire logic [NUM_TAPS-1:0][COEF_W-1:0]     coef_i,
   output logic                                     out_valid_o,
   output logic [SAMPLE_W-1:0]                      out_data_o
);
   localparam logic signed [ACC_W-1:0] SAT_MAX = ACC_W'((2**(SAMPLE_W-1)) - 1);
   localparam logic signed [ACC_W-1:0] SAT_MIN = -ACC_W'(2**(SAMPLE_W-1));

   logic [SAMPLE_W-1:0]           line_reg [NUM_TAPS-1];
   logic signed [ACC_W-1:0]       acc;
   logic signed [ACC_W-1:0]       scaled;
   logic signed [SAMPLE_W+COEF_W-1:0] prod;
   logic [SAMPLE_W-1:0]           win;

   generate
      if (NUM_TAPS < 2 || ACC_W < SAMPLE_W + COEF_W + 3)
      begin : g_chk
         $error("fir_mac: unsupported tap count or accumulator width");
      end
   endgenerate

   always_comb
   begin
      acc  = '0;
      prod = '0;
      win  = '0;
      for (int k = 0; k < NUM_TAPS; k++)
      begin
         win  = (k == 0) ? in_data_i : line_reg[(k == 0) ? 0 : k-1];
         prod = $signed(win) * $signed(coef_i[k]);
         acc  = acc + ACC_W'(prod);
      end
      scaled = acc >>> FRAC;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int k = 0; k < NUM_TAPS-1; k++)
         begin
            line_reg[k] <= '0;
         end
      end
      else if (in_valid_i)
      begin
         line_reg[0] <= in_data_i;
         for (int k = 1; k < NUM_TAPS-1; k++)
         begin
            line_reg[k] <= line_reg[k-1];
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
      end
      else
      begin
         out_valid_o <= in_valid_i;
         if (in_valid_i)
         begin
            if (!enable_i)
               out_data_o <= in_data_i;
            else if (scaled > SAT_MAX)
               out_data_o <= SAT_MAX[SAMPLE_W-1:0];
            else if (scaled < SAT_MIN)
               out_data_o <= SAT_MIN[SAMPLE_W-1:0];
            else
               out_data_o <= scaled[SAMPLE_W-1:0];
         end
      end
   end
endmodule

//--- sim/equalizer_fir_bank_assertions.sv
// port level assertion checker for the equalizer fir coefficient bank
`timescale 1ns/100ps
module equalizer_fir_bank_checker
   import equalizer_fir_pkg::*;
(
   input  wire logic                                   clk_sys_i,
   input  wire logic                                   rst_n_i,
   input  wire equalizer_fir_pkg::apb_req_s            apb_i,
   input  wire logic [equalizer_fir_pkg::DATA_W-1:0]   prdata_o,
   input  wire logic                                   pready_o,
   input  wire logic                                   pslverr_o,
   input  wire logic                                   serial_link_output_enable_i,
   input  wire equalizer_fir_pkg::sample_s             sample_i,
   input  wire equalizer_fir_pkg::sample_s             sample_o,
   input  wire logic                                   fir_active_o
);
   localparam logic [ADDR_W-1:0] A_CFG = {IDX_CFG[13:0], 2'b00};
   localparam logic [ADDR_W-1:0] A_CTR = {IDX_CENTRE[13:0], 2'b00};
   wire logic cfg_wr;
   wire logic rd_side;
   assign cfg_wr = apb_i.psel & apb_i.penable & apb_i.pwrite & pready_o & (apb_i.paddr == A_CFG);
   assign rd_side = pready_o & ~apb_i.pwrite & (apb_i.paddr inside {{IDX_TAP0[13:0], 2'b00},
      {IDX_TAP1[13:0], 2'b00}, {IDX_TAP2[13:0], 2'b00}, {IDX_TAP3[13:0], 2'b00}});

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   sequence seq_setup;
      apb_i.psel && !apb_i.penable;
   endsequence
   sequence seq_one_wait;
      !pready_o ##1 pready_o;
   endsequence
   sequence seq_bypass_sample;
      sample_i.valid && !fir_active_o ##1 !fir_active_o;
   endsequence

   AST_ONE_WAIT: assert property (seq_setup |=> seq_one_wait)
      else $error("answer not after exactly one wait state");
   AST_READY_PULSE: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   AST_READY_IN_ACCESS: assert property (pready_o |-> apb_i.psel && apb_i.penable)
      else $error("ready outside access phase");
   AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   AST_SIDE_UPPER_ZERO: assert property (rd_side |-> prdata_o[31:16] == 16'h0000)
      else $error("side register read beyond sixteen bits");
   AST_CTR_UPPER_ZERO: assert property (pready_o && !apb_i.pwrite && apb_i.paddr == A_CTR |-> prdata_o[31:24] == 8'h00)
      else $error("centre register read beyond twenty four bits");
   AST_SAMPLE_LAT: assert property (sample_i.valid |=> sample_o.valid)
      else $error("output sample missing one cycle after input");
   AST_BYPASS: assert property (seq_bypass_sample |-> sample_o.data == $past(sample_i.data))
      else $error("bypass output differs from input");
   AST_ACTIVE_FROM_CFG: assert property ($rose(fir_active_o) |-> $past(cfg_wr) || $past(cfg_wr, 2))
      else $error("filter enabled without config write");
   AST_RESET_QUIET: assert property ($rose(rst_n_i) |-> !pready_o && !sample_o.valid && !fir_active_o)
      else $error("outputs active right after reset");
endmodule

bind equalizer_fir_bank equalizer_fir_bank_checker chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .apb_i(apb_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .serial_link_output_enable_i(serial_link_output_enable_i), .sample_i(sample_i), .sample_o(sample_o),
   .fir_active_o(fir_active_o));

//--- sim/tb.sv
// self-checking bench for the equalizer fir coefficient bank
`timescale 1ns/100ps
module tb;
   import equalizer_fir_pkg::*;
   typedef struct packed {logic rd; logic err; logic act; logic [DATA_W-1:0] d;} exp_apb_s;
   logic              act_now = 1'b0;
   logic              clk_sys_i = 1'b0;
   logic              rst_n_i = 1'b0;
   apb_req_s          apb_i = '0;
   logic [DATA_W-1:0] prdata_o;
   logic              pready_o;
   logic              pslverr_o;
   logic              link_en = 1'b0;
   sample_s           sample_i = '0;
   sample_s           sample_o;
   logic              fir_active_o;
   exp_apb_s          apb_q[$];
   exp_apb_s          ea;
   logic [12:0]       smp_q[$];
   logic [12:0]       es;
   int                fail_count = 0;
   int                cmp_count = 0;
   logic [15:0]       seed = 16'h0014;
   logic [11:0]       side [NUM_SIDE];
   logic [17:0]       ctr;
   logic [11:0]       hist [NUM_TAPS];
   int                w;
   logic [1:0]        mode;
   logic [DATA_W-1:0] d;
   logic [7:0]        cfg;
   logic [ADDR_W-1:0] idx_tab [NUM_TAPS] = '{IDX_TAP0, IDX_TAP1, IDX_TAP2, IDX_TAP3, IDX_CENTRE};

   always #5 clk_sys_i = ~clk_sys_i;

   equalizer_fir_bank dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .serial_link_output_enable_i(link_en),
      .sample_i(sample_i), .sample_o(sample_o), .fir_active_o(fir_active_o));

   function automatic logic [DATA_W-1:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      rnd[31:16] = seed;
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      rnd[15:0] = seed;
   endfunction

   function automatic logic [ADDR_W-1:0] ba(input logic [ADDR_W-1:0] i);
      ba = {i[ADDR_W-3:0], 2'b00};
   endfunction

   // reference filter over the model history
   function automatic logic [11:0] fir_out();
      longint acc;
      longint c;
      acc = 0;
      for (int k = 0; k < NUM_TAPS; k++)
      begin
         c = (k < NUM_SIDE) ? (longint'($signed(side[k])) <<< (w > 6 ? 6 : w)) : longint'($signed(ctr));
         acc += c * longint'($signed(hist[k]));
      end
      acc = acc >>> FRAC_BITS;
      if (acc > 2047) acc = 2047;
      if (acc < -2048) acc = -2048;
      fir_out = acc[11:0];
   endfunction

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                      input logic [DATA_W-1:0] ed, input logic ee);
      int n;
      @(posedge clk_sys_i);
      apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      apb_q.push_back('{rd: !wr, err: ee, act: act_now, d: ed});
      @(posedge clk_sys_i);
      apb_i.penable <= 1'b1;
      for (n = 0; n < 20 && pready_o !== 1'b1; n++) @(negedge clk_sys_i);
      if (pready_o !== 1'b1)
      begin
         fail_count++;
         $display("BAD %0t bus timeout", $time);
         stop_test();
      end
      @(posedge clk_sys_i);
      apb_i <= '0;
   endtask

   // vm: 0 idle, 1 valid, 2 random valid
   task automatic send(input logic [1:0] vm, input logic skip);
      logic [DATA_W-1:0] r;
      logic v;
      r = rnd();
      v = vm[0] | (vm[1] & r[12]);
      @(posedge clk_sys_i);
      sample_i <= '{valid: v, data: r[11:0]};
      if (v)
      begin
         for (int k = NUM_TAPS - 1; k > 0; k--) hist[k] = hist[k-1];
         hist[0] = r[11:0];
         smp_q.push_back({skip, (mode == FM_ENABLE) ? fir_out() : r[11:0]});
      end
   endtask

   always @(negedge clk_sys_i)
   begin
      if (rst_n_i && pready_o === 1'b1 && apb_q.size() > 0)
      begin
         ea = apb_q.pop_front();
         check(DATA_W'(pslverr_o), DATA_W'(ea.err));
         check(DATA_W'(fir_active_o), DATA_W'(ea.act));
         if (ea.rd) check(prdata_o, ea.d);
      end
      if (rst_n_i && sample_o.valid === 1'b1 && smp_q.size() > 0)
      begin
         es = smp_q.pop_front();
         if (!es[12]) check(DATA_W'(sample_o.data), DATA_W'(es[11:0]));
      end
   end

   initial
   begin
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      for (int i = 0; i < NUM_TAPS; i++) apb(0, ba(idx_tab[i]), 0, 0, 0);
      apb(0, ba(IDX_CFG), 0, 0, 0);
      apb(0, ba(IDX_STATUS), 0, 0, 0);
      apb(0, ba(16'h0419), 0, 0, 1);
      apb(0, ba(IDX_TAP1) + 16'h0001, 0, 0, 1);
      apb(1, ba(16'h0419), 32'hFFFF_FFFF, 0, 1);
      for (int r = 0; r < 8; r++)
      begin
         w = r;
         mode = (r < 4) ? 2'(r) : FM_ENABLE;
         for (int i = 0; i < NUM_TAPS; i++)
         begin
            d = rnd();
            apb(1, ba(idx_tab[i]), d, 0, 0);
            apb(0, ba(idx_tab[i]), 0, d & ((i == CENTRE_IDX) ? 32'h00FF_FFFF : 32'h0000_FFFF), 0);
            if (i < NUM_SIDE) side[i] = d[11:0];
            else ctr = d[17:0];
         end
         cfg = {2'b00, r[0], 3'(r), mode};
         apb(1, ba(IDX_CFG), DATA_W'(cfg), 0, 0);
         act_now = (mode == FM_ENABLE);
         apb(0, ba(IDX_CFG), 0, DATA_W'(cfg), 0);
         repeat (NUM_TAPS) send(2'd1, 1'b1);
         repeat (24) send(2'd2, 1'b0);
         send(2'd0, 1'b0);
      end
      repeat (4) @(posedge clk_sys_i);
      link_en <= 1'b1;
      apb(1, ba(IDX_CFG), DATA_W'(cfg), 0, 0);
      apb(0, ba(IDX_STATUS), 0, 32'h0000_003B, 0);
      apb(1, ba(IDX_STATUS), 32'h0000_0010, 0, 0);
      apb(0, ba(IDX_STATUS), 0, 32'h0000_002B, 0);
      link_en <= 1'b0;
      apb(0, ba(IDX_STATUS), 0, 32'h0000_000B, 0);
      if (smp_q.size() != 0 || apb_q.size() != 0) check(1, 0);
      stop_test();
   end
endmodule
